// file: pst_i2c_target.sv
// Two-wire bus target: start/stop detection, addressing and acknowledge.
`timescale 1ns/1ps
`default_nettype none
`include "pst_defines.svh"
module pst_i2c_target
  import pst_pkg::*;
#(
  parameter int FILTER_LEN = `PST_FILTER_LEN
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bus lines, open drain: only low drive is ever enabled.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  // Strap and status.
  input wire logic address_select_strap,
  output pst_status_type status,
  output logic start_seen,
  output logic stop_seen
);
  pst_bus_type sync1, sync2, filt, filt_d;
  logic [FILTER_LEN-1:0] scl_hist, sda_hist;
  logic strap1, strap2;
  logic [6:0] own_addr;
  pst_state_type state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic framing;
  logic addr_done;
  logic ack_give;
  logic ack_end;

  // The line moves only after every stored sample agrees; anything shorter is a spike.
  function automatic logic line_filter(
    input logic [FILTER_LEN-1:0] hist,
    input logic prev
  );
    logic next_level;
    next_level = prev;
    if (&hist) begin
      next_level = 1'b1;
    end else if (~|hist) begin
      next_level = 1'b0;
    end
    return next_level;
  endfunction

  // Seven address bits lead the first byte; the direction bit comes last.
  function automatic logic addr_match(
    input logic [7:0] frame,
    input logic [6:0] own
  );
    return frame[7:1] == own;
  endfunction

  // Bit counter step, shared by the address and data phases.
  function automatic logic [3:0] count_up(input logic [3:0] value);
    return value + 4'h1;
  endfunction

  // Two flip-flops per line; the first is read only by the second.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= '1;
      sync2 <= '1;
      strap1 <= 1'b0;
      strap2 <= 1'b0;
    end else begin
      sync1 <= '{scl: scl_in, sda: sda_in};
      sync2 <= sync1;
      strap1 <= address_select_strap;
      strap2 <= strap1;
    end
  end

  // A line changes only after FILTER_LEN equal samples, which rejects short spikes.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_hist <= '1;
      sda_hist <= '1;
      filt <= '1;
      filt_d <= '1;
    end else begin
      scl_hist <= {scl_hist[FILTER_LEN-2:0], sync2.scl};
      sda_hist <= {sda_hist[FILTER_LEN-2:0], sync2.sda};
      filt.scl <= line_filter(scl_hist, filt.scl); // [RULE12]
      filt.sda <= line_filter(sda_hist, filt.sda); // [RULE12]
      filt_d <= filt;
    end
  end

  assign scl_rise = filt.scl & ~filt_d.scl;
  assign scl_fall = ~filt.scl & filt_d.scl;
  // Data edges with clock high are framing, never data.
  assign start_ev = filt.scl & filt_d.scl & filt_d.sda & ~filt.sda; // [RULE4] [RULE10]
  assign stop_ev = filt.scl & filt_d.scl & ~filt_d.sda & filt.sda; // [RULE8] [RULE10]

  // The strap is sampled continuously so a board change is seen without reset.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      own_addr <= 7'h00;
    end else begin
      own_addr <= {`PST_ADDR_FIXED, strap2}; // [RULE2] [RULE3]
    end
  end

  // Bit-level decode shared by the blocks below; framing events win over bit events.
  assign framing = start_ev | stop_ev;
  assign addr_done = (state == PST_ADDR) && scl_fall && (bit_cnt == `PST_BIT_COUNT) && !framing;
  assign ack_give = addr_done && addr_match(shift, own_addr); // [RULE2] [RULE3]
  assign ack_end = (state == PST_ACK) && scl_fall && !framing; // [RULE7]

  // Transfer sequencing.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= PST_IDLE;
      bit_cnt <= 4'h0;
    end else if (start_ev) begin
      state <= PST_ADDR; // [RULE4]
      bit_cnt <= 4'h0;
    end else if (stop_ev) begin
      state <= PST_IDLE; // [RULE8]
    end else begin
      case (state)
        PST_IDLE: begin
          state <= PST_IDLE; // [RULE11]
        end
        PST_ADDR: begin
          if (scl_rise) begin
            bit_cnt <= count_up(bit_cnt); // [RULE5]
          end
          if (ack_give) begin
            state <= PST_ACK; // [RULE7]
          end else if (addr_done) begin
            state <= PST_IDLE; // [RULE11]
          end
        end
        PST_ACK: begin
          // Released on the fall that ends the ninth pulse, or earlier on a start or stop.
          if (ack_end) begin
            bit_cnt <= 4'h0;
            state <= PST_DATA;
          end
        end
        PST_DATA: begin
          // Data bytes belong to the register layer; this port only frames them.
          if (scl_rise) begin
            bit_cnt <= count_up(bit_cnt);
          end
          if (scl_fall && bit_cnt == `PST_ACK_COUNT) begin
            bit_cnt <= 4'h0;
          end
        end
        default: state <= PST_IDLE;
      endcase
    end
  end

  // Sampled on the clock rise, when the host holds data stable.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shift <= 8'h00;
    end else if (state == PST_ADDR && scl_rise && !framing) begin
      shift <= {shift[6:0], filt.sda}; // [RULE5] [RULE9]
    end
  end

  // Active from a matched address until the next start or stop.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      status <= '0;
    end else if (framing) begin
      status.active <= 1'b0; // [RULE8]
    end else if (ack_give) begin
      status.addr <= shift[7:1];
      status.read <= shift[0]; // [RULE6]
      status.active <= 1'b1;
    end
  end

  // Data is pulled low only through the ninth pulse after a match, released otherwise.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else if (framing || ack_end || state == PST_IDLE) begin
      sda_out <= 1'b1;
      sda_oe <= 1'b0; // [RULE11]
    end else if (ack_give) begin
      sda_out <= 1'b0; // [RULE1] [RULE7]
      sda_oe <= 1'b1;
    end
  end

  // Event pulses, one cycle each.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end else begin
      start_seen <= start_ev;
      stop_seen <= stop_ev;
    end
  end

  // The clock line is never stretched, so it stays released.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_out <= 1'b1;
      scl_oe <= 1'b0;
    end else begin
      scl_out <= 1'b1;
      scl_oe <= 1'b0; // [RULE1]
    end
  end
endmodule
`default_nettype wire

// file: pst_defines.svh
// Constants for the two-wire target port of the pressure sensor.
// Contract
// RULE1 - Both parties only pull lines low or release them; pull-ups give idle high.
// RULE2 - Device answers a seven-bit address with fixed upper bits per address table.
// RULE3 - Address least significant bit follows the strapped address-select pin level.
// RULE4 - Data falling while clock high is start; device detects it, begins transfer.
// RULE5 - Host shifts address out after start, most significant bit first, one per clock.
// RULE6 - Eighth bit is direction, high read, low write; device latches it.
// RULE7 - On address match, device holds data low throughout the ninth clock pulse.
// RULE8 - Data rising while clock high is stop; device ends transfer on it.
// RULE9 - Transmitter keeps data stable while clock is high during a data bit.
// RULE10 - Transmitter changes data only while clock low; else read as start or stop.
// RULE11 - On mismatch device releases data for ack and later bits until next start.
// RULE12 - Device synchronises and filters both lines before detecting edges.
`ifndef PST_DEFINES_SVH
`define PST_DEFINES_SVH
`define PST_ADDR_FIXED 6'h36
`define PST_FILTER_LEN 3
`define PST_BIT_COUNT 4'h8
`define PST_ACK_COUNT 4'h9
`endif

// file: pst_pkg.sv
// Types for the two-wire target port of the pressure sensor.
package pst_pkg;
  typedef enum logic [1:0] {PST_IDLE, PST_ADDR, PST_ACK, PST_DATA} pst_state_type;
  typedef struct packed {
    logic scl;
    logic sda;
  } pst_bus_type;
  typedef struct packed {
    logic active;
    logic read;
    logic [6:0] addr;
  } pst_status_type;
endpackage

// file: pst_i2c_target_props.sv
// Assertions on the two-wire target port.
`timescale 1ns/1ps
`default_nettype none
`include "pst_defines.svh"
module pst_i2c_target_props
  import pst_pkg::*;
#(
  parameter int FILTER_LEN = `PST_FILTER_LEN
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bus lines as resolved on the wires.
  input wire logic scl_in,
  input wire logic sda_in,
  // Line drive of the target.
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic sda_out,
  // Strap and status.
  input wire logic address_select_strap,
  input wire logic start_seen,
  input wire logic stop_seen,
  input wire pst_status_type status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  scl_free_a: assert property (!scl_oe)
    else $error("clock driven");
  sda_od_a: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  own_addr_a: assert property ($rose(sda_oe) |->
      status.addr == {`PST_ADDR_FIXED, address_select_strap})
    else $error("ack to foreign address");
  start_det_a: assert property (
      (scl_in && sda_in)[*4] ##1 (scl_in && !sda_in)[*4] |-> ##[0:8] start_seen)
    else $error("start missed");
  stop_det_a: assert property (
      (scl_in && !sda_in)[*4] ##1 (scl_in && sda_in)[*4] |-> ##[0:8] stop_seen)
    else $error("stop missed");
  stop_clr_a: assert property (stop_seen |=> !status.active)
    else $error("active after stop");
  ack_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved, clock high");
  ack_hold_a: assert property ($rose(scl_in) && sda_oe |-> sda_oe[*8])
    else $error("ack dropped");
  match_only_a: assert property (sda_oe |-> status.active)
    else $error("ack unmatched");
endmodule
bind pst_i2c_target pst_i2c_target_props #(.FILTER_LEN(FILTER_LEN)) props_i (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .sda_out(sda_out), .address_select_strap(address_select_strap), .start_seen(start_seen),
  .stop_seen(stop_seen), .status(status));
`default_nettype wire

// file: pst_host.sv
// Bus controller model that addresses the target.
`timescale 1ns/1ps
`default_nettype none
module pst_host (
  output logic scl_oe,
  output logic sda_oe,
  input wire logic sda
);
  initial begin
    scl_oe = 0;
    sda_oe = 0;
  end
  task start; #700 sda_oe = 1; #700 scl_oe = 1; endtask
  // Data moves 600 ns into the low phase, so the target's filter never sees it with clock high.
  task wbyte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      scl_oe = 1;
      #600 sda_oe = (i > 0) ? !b[i - 1] : 1'b0;
      #700 scl_oe = 0;
      #400 ack = sda;
      #400;
    end
    scl_oe = 1;
  endtask
  task stop; #600 sda_oe = 1; #700 scl_oe = 0; #700 sda_oe = 0; #1400; endtask
  task glitch; sda_oe = 1; #40 sda_oe = 0; endtask
endmodule
`default_nettype wire

// file: pst_i2c_target_tb.sv
// Testbench for the two-wire target port.
`timescale 1ns/1ps
`default_nettype none
module pst_i2c_target_tb import pst_pkg::*;;
  logic clk_sys = 0, sys_rst = 1, strap = 0, ack, h_scl, h_sda, scl_oe, sda_oe, start_seen;
  logic stop_seen;
  int bad_count = 0, checked = 0, starts = 0, stops = 0;
  pst_status_type status;
  wire scl = !(h_scl | scl_oe);
  wire sda = !(h_sda | sda_oe);
  pst_host pst_host_i (.scl_oe(h_scl), .sda_oe(h_sda), .sda(sda));
  pst_i2c_target pst_i2c_target_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
    .address_select_strap(strap), .status(status), .start_seen(start_seen), .stop_seen(stop_seen));
  initial forever #12.5 clk_sys = !clk_sys;
  always @(posedge clk_sys) if (start_seen === 1'b1) starts++;
  always @(posedge clk_sys) if (stop_seen === 1'b1) stops++;
  task chk(string n, logic [8:0] s, e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task finish_test;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task xfer(logic st, logic [7:0] b, logic e);
    int n, m;
    @(posedge clk_sys) #2 strap = st;
    #2000 n = starts;
    m = stops;
    pst_host_i.start;
    pst_host_i.wbyte(b, ack);
    chk("ack", 9'(ack), 9'(!e));
    chk("active", 9'(status.active), 9'(e));
    if (e) chk("status", status, {1'b1, b[0], b[7:1]});
    pst_host_i.wbyte(8'h55, ack);
    chk("data ack", 9'(ack), 9'h1);
    pst_host_i.stop;
    chk("starts", 9'(starts), 9'(n + 1));
    chk("stops", 9'(stops), 9'(m + 1));
    chk("end", 9'(status.active), 9'h0);
  endtask
  task glitch;
    int n;
    n = starts;
    pst_host_i.glitch;
    #2000 chk("glitch", 9'(starts), 9'(n));
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #2 sys_rst = 0;
    xfer(0, 8'hd8, 1);
    xfer(0, 8'hd9, 1);
    xfer(0, 8'hda, 0);
    xfer(1, 8'hdb, 1);
    xfer(1, 8'hd8, 0);
    glitch;
    finish_test;
  end
  initial begin
    #1000000 bad_count++;
    finish_test;
  end
endmodule
`default_nettype wire
